/* File: fsrec_core.sv */
`timescale 1ns/1ps
// Core side: issues register accesses and counts the stall cycles
module fsrec_core #(
    parameter int EC = 64
) (
    input wire logic                         clk,
    input wire logic                         cpu_stall,
    input wire logic                         instr_squash,
    input wire logic [fsrec_pkg::DATA_W-1:0] bus_rdata_q,
    output fsrec_pkg::fsrec_bus_req_s        bus_req
);
    import fsrec_pkg::*;
    initial bus_req = '0;
    // Write strobe held until the next access or idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    endtask
    task automatic idle();
        @(posedge clk);
        bus_req <= '0;
    endtask
    // Read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        idle();
        #1 d = bus_rdata_q;
    endtask
    task automatic pread(input logic [15:0] a, output int sq, output logic [15:0] w);
        logic [7:0] lo, hi;
        wr(OFS_ADDR_LOW, a[7:0]);
        wr(OFS_ADDR_HIGH, a[15:8]);
        wr(OFS_CTRL, 8'h01);
        idle();
        sq = 0;
        for (int i = 1; i < 5; i++) begin
            #1 if (instr_squash !== 1'b0) sq = i;
            @(posedge clk);
        end
        rd(OFS_DATA_LOW, lo);
        rd(OFS_DATA_HIGH, hi);
        w = {hi, lo};
    endtask
    // row setup, unlock, start, then count the stall cycles
    task automatic erase(input logic [15:0] a, input logic [7:0] k2, input logic [7:0] c,
                         output int n);
        wr(OFS_ADDR_LOW, a[7:0]);
        wr(OFS_ADDR_HIGH, a[15:8]);
        wr(OFS_CTRL, 8'h14);
        wr(OFS_UNLOCK, UNLOCK_KEY1);
        wr(OFS_UNLOCK, k2);
        wr(OFS_CTRL, c);
        idle();
        n = 0;
        repeat (EC + 8) begin
            @(posedge clk);
            #1 if (cpu_stall !== 1'b0) n++;
        end
    endtask
endmodule

/* File: fsrec_ctrl.sv */
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - Read uses second cycle, squashing that instruction
// - Read word lands next cycle, held
// - Erase whole 32-word rows only
// - Erase only after 55h then AAh unlock
// - Two setup cycles after write start
// - Stall core for erase time, clocks run
// - Resume at third instruction after start
// - Protect ranges for 4 kW array
// - Protect ranges for 8 kW array
module fsrec_ctrl
    import fsrec_pkg::*;
#(
    parameter int AW           = 13,
    parameter bit ARRAY_8KW    = 1'b1,
    parameter int ERASE_CYCLES = fsrec_pkg::ERASE_CYCLES
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire fsrec_pkg::fsrec_bus_req_s  bus_req,
    output logic [fsrec_pkg::DATA_W-1:0]    bus_rdata_q,
    input  wire logic [1:0]                 self_write_protect_field,
    output logic                            cpu_stall,
    output logic                            instr_squash
);
    import fsrec_pkg::*;

    localparam int CNT_W = $clog2(ERASE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(ERASE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ROW  = CNT_W'(ROW_WORDS - 1);

    fsrec_state_e           state_q;
    fsrec_ctrl_s            ctrl_q;
    logic [7:0]             prog_addr_low_q;
    logic [ADDR_HIGH_W-1:0] prog_addr_high_q;
    logic [7:0]             prog_data_low_q;
    logic [WORD_HIGH_W-1:0] prog_data_high_q;
    logic                   key1_seen_q;
    logic                   unlocked_q;
    logic [CNT_W-1:0]       cnt_q;
    logic [WORD_W-1:0]      mem_rdata;
    logic [15:0]            full_addr;
    logic [AW-1:0]          row_base;
    logic                   wr_ctrl;
    logic                   wr_unlock;
    logic                   start_rd;
    logic                   req_wr;
    logic                   start_wr;

    // Address of a protected word under the current protect field
    function automatic logic is_protected(input logic [15:0] a, input logic [1:0] f);
        logic [15:0] lim;
        lim = 16'h0000;
        case (f)
            PROT_OFF:  lim = 16'h0000;
            PROT_BOOT: lim = LIM_BOOT;
            PROT_HALF: lim = ARRAY_8KW ? LIM_HALF8K : LIM_HALF4K;
            default:   lim = ARRAY_8KW ? LIM_ALL8K : LIM_ALL4K;
        endcase
        return a < lim;
    endfunction

    // Register strobe decode
    function automatic logic hit(input fsrec_bus_req_s r, input logic [2:0] ofs);
        return r.we && (r.addr == ofs);
    endfunction

    // Request decode
    assign full_addr = {1'b0, prog_addr_high_q, prog_addr_low_q};
    assign row_base  = {full_addr[AW-1:5], 5'h00};
    assign wr_ctrl   = hit(bus_req, OFS_CTRL);
    assign wr_unlock = hit(bus_req, OFS_UNLOCK);
    assign start_rd  = wr_ctrl && bus_req.wdata[BIT_RD] && (state_q == ST_IDLE);
    assign req_wr    = wr_ctrl && bus_req.wdata[BIT_WR] && (state_q == ST_IDLE);
    assign start_wr  = req_wr && bus_req.wdata[BIT_WRITE_ENABLE_BIT] && bus_req.wdata[BIT_FREE]
                       && !bus_req.wdata[BIT_CONFIG_SPACE_SELECT] && unlocked_q
                       && !is_protected(full_addr, self_write_protect_field);

    // Core handshakes
    // stall during erase
    assign cpu_stall    = (state_q == ST_ER_CLR) || (state_q == ST_ER_WT);
    assign instr_squash = (state_q == ST_RD_END);

    // Sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_wr) begin
                        state_q <= ST_ER_SU1;
                    end else if (start_rd && !req_wr) begin
                        state_q <= ST_RD_ACC;
                    end
                end
                ST_RD_ACC: state_q <= ST_RD_END;
                ST_RD_END: state_q <= ST_IDLE;
                ST_ER_SU1: state_q <= ST_ER_SU2;
                ST_ER_SU2: state_q <= ST_ER_CLR;
                ST_ER_CLR: begin
                    if (cnt_q == CNT_ROW) begin
                        state_q <= ST_ER_WT;
                    end
                end
                ST_ER_WT: begin
                    if (cnt_q >= CNT_LAST) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Erase cycle counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if ((state_q == ST_ER_CLR) || (state_q == ST_ER_WT)) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end else begin
            cnt_q <= '0;
        end
    end

    // Unlock tracking: 55h then AAh, consumed by the next control write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            key1_seen_q <= 1'b0;
            unlocked_q  <= 1'b0;
        end else if (wr_unlock) begin
            key1_seen_q <= (bus_req.wdata == UNLOCK_KEY1);
            unlocked_q  <= key1_seen_q && (bus_req.wdata == UNLOCK_KEY2);
        end else if (wr_ctrl) begin
            key1_seen_q <= 1'b0;
            unlocked_q  <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q.config_space_select <= bus_req.wdata[BIT_CONFIG_SPACE_SELECT];
                ctrl_q.free <= bus_req.wdata[BIT_FREE];
                ctrl_q.write_enable_bit <= bus_req.wdata[BIT_WRITE_ENABLE_BIT];
                ctrl_q.err  <= bus_req.wdata[BIT_ERR] && ctrl_q.err;
            end
            if (start_rd && !start_wr && !req_wr) begin
                ctrl_q.rd <= 1'b1;
            end
            if (start_wr) begin
                ctrl_q.wr <= 1'b1;
            end
            // flag a refused start, set wins
            if (req_wr && !start_wr) begin
                ctrl_q.err <= 1'b1;
            end
            if (state_q == ST_RD_END) begin
                ctrl_q.rd <= 1'b0;
            end
            if ((state_q == ST_ER_WT) && (cnt_q >= CNT_LAST)) begin
                ctrl_q.wr <= 1'b0;
            end
        end
    end

    // Address registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_addr_low_q  <= ADDR_LOW_RST;
            prog_addr_high_q <= ADDR_HIGH_RST;
        end else begin
            if (hit(bus_req, OFS_ADDR_LOW)) begin
                prog_addr_low_q <= bus_req.wdata;
            end
            if (hit(bus_req, OFS_ADDR_HIGH)) begin
                prog_addr_high_q <= bus_req.wdata[ADDR_HIGH_W-1:0];
            end
        end
    end

    // Data registers: loaded by a read, otherwise by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_data_low_q  <= DATA_LOW_RST;
            prog_data_high_q <= DATA_HIGH_RST;
        end else if (state_q == ST_RD_END) begin
            prog_data_low_q  <= ctrl_q.config_space_select ? 8'h00 : mem_rdata[7:0];
            prog_data_high_q <= ctrl_q.config_space_select ? 6'h00 : mem_rdata[WORD_W-1:8];
        end else begin
            if (hit(bus_req, OFS_DATA_LOW)) begin
                prog_data_low_q <= bus_req.wdata;
            end
            if (hit(bus_req, OFS_DATA_HIGH)) begin
                prog_data_high_q <= bus_req.wdata[WORD_HIGH_W-1:0];
            end
        end
    end

    // Register read-back, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata_q <= '0;
        end else if (bus_req.re) begin
            case (bus_req.addr)
                OFS_CTRL:      bus_rdata_q <= {1'b0, ctrl_q.config_space_select, 1'b0, ctrl_q.free,
                                               ctrl_q.err, ctrl_q.write_enable_bit, ctrl_q.wr, ctrl_q.rd};
                OFS_ADDR_LOW:  bus_rdata_q <= prog_addr_low_q;
                OFS_ADDR_HIGH: bus_rdata_q <= {1'b0, prog_addr_high_q};
                OFS_DATA_LOW:  bus_rdata_q <= prog_data_low_q;
                OFS_DATA_HIGH: bus_rdata_q <= {2'b00, prog_data_high_q};
                default:       bus_rdata_q <= '0;
            endcase
        end else begin
            bus_rdata_q <= '0;
        end
    end

    // Program array; erase writes the 32 words of the addressed row
    fsrec_mem #(
        .DW (WORD_W),
        .AW (AW)
    ) u_mem (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (state_q == ST_ER_CLR),
        .waddr   (row_base | AW'(cnt_q[4:0])),
        .wdata   (ERASED_WORD),
        .raddr   (full_addr[AW-1:0]),
        .rdata_q (mem_rdata)
    );

endmodule

/* File: fsrec_ctrl_asserts.sv */
`timescale 1ns/1ps
// Port-level checks of the flash sequencer
module fsrec_ctrl_asserts #(
    parameter int ERASE_CYCLES = 64
) (
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire fsrec_pkg::fsrec_bus_req_s    bus_req,
    input wire logic [fsrec_pkg::DATA_W-1:0] bus_rdata_q,
    input wire logic [1:0]                   self_write_protect_field,
    input wire logic                         cpu_stall,
    input wire logic                         instr_squash
);
    import fsrec_pkg::*;
    logic [31:0] stall_cnt_q;
    wire         ctl_w = bus_req.we && bus_req.addr == OFS_CTRL;
    wire         key_w = bus_req.we && bus_req.addr == OFS_UNLOCK;
    // Length of the current stall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stall_cnt_q <= '0;
        end else begin
            stall_cnt_q <= cpu_stall ? stall_cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_sq_cause;
        $rose(instr_squash) |-> $past(ctl_w && bus_req.wdata[BIT_RD], 2);
    endproperty
    a_sq_cause: assert property (p_sq_cause) else $error("squash without read start");
    property p_sq_pulse;
        instr_squash |=> !instr_squash;
    endproperty
    a_sq_pulse: assert property (p_sq_pulse) else $error("squash longer than one cycle");
    property p_rd_idle;
        !bus_req.re |=> bus_rdata_q == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
    property p_er_len;
        $fell(cpu_stall) |-> stall_cnt_q == ERASE_CYCLES;
    endproperty
    a_er_len: assert property (p_er_len) else $error("erase stall length wrong");
    property p_er_max;
        cpu_stall |-> stall_cnt_q < ERASE_CYCLES;
    endproperty
    a_er_max: assert property (p_er_max) else $error("erase stall too long");
    property p_er_key;
        $rose(cpu_stall) |-> $past(key_w && bus_req.wdata == UNLOCK_KEY2, 4)
            && $past(key_w && bus_req.wdata == UNLOCK_KEY1, 5);
    endproperty
    a_er_key: assert property (p_er_key) else $error("erase without unlock");
    property p_er_setup;
        $rose(cpu_stall) |-> $past(ctl_w && bus_req.wdata[BIT_WR] && bus_req.wdata[BIT_WRITE_ENABLE_BIT], 3);
    endproperty
    a_er_setup: assert property (p_er_setup) else $error("erase setup slots wrong");
    property p_er_prot;
        $rose(cpu_stall) |-> $past(self_write_protect_field, 3) != 2'h0;
    endproperty
    a_er_prot: assert property (p_er_prot) else $error("erase while all protected");
    property p_no_sq;
        cpu_stall |-> !instr_squash;
    endproperty
    a_no_sq: assert property (p_no_sq) else $error("squash during stall");
endmodule

/* File: fsrec_mem.sv */
`timescale 1ns/1ps

// Program word array with registered read data
module fsrec_mem #(
    parameter int DW = 14,
    parameter int AW = 13
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_q
);

    logic [DW-1:0] mem [2**AW];

    // Write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

/* File: fsrec_pkg.sv */
package fsrec_pkg;

    // Register map, one byte-wide register per index
    localparam logic [2:0] OFS_CTRL      = 3'h0;
    localparam logic [2:0] OFS_ADDR_LOW  = 3'h1;
    localparam logic [2:0] OFS_ADDR_HIGH = 3'h2;
    localparam logic [2:0] OFS_DATA_LOW  = 3'h3;
    localparam logic [2:0] OFS_DATA_HIGH = 3'h4;
    localparam logic [2:0] OFS_UNLOCK    = 3'h5;

    // Control register bit positions
    localparam int BIT_RD   = 0;
    localparam int BIT_WR   = 1;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_ERR  = 3;
    localparam int BIT_FREE = 4;
    localparam int BIT_CONFIG_SPACE_SELECT = 6;

    // Field widths
    localparam int DATA_W      = 8;
    localparam int ADDR_HIGH_W = 7;
    localparam int WORD_W      = 14;
    localparam int WORD_HIGH_W = 6;

    // Reset values
    localparam logic [7:0]             ADDR_LOW_RST  = 8'h00;
    localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RST = 7'h00;
    localparam logic [7:0]             DATA_LOW_RST  = 8'h00;
    localparam logic [WORD_HIGH_W-1:0] DATA_HIGH_RST = 6'h00;

    // Unlock sequence bytes
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;

    // Row geometry and erased word value
    localparam int                ROW_WORDS   = 32;
    localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;

    // Protect field encodings and protected upper bounds (exclusive)
    localparam logic [1:0]  PROT_OFF   = 2'h3;
    localparam logic [1:0]  PROT_BOOT  = 2'h2;
    localparam logic [1:0]  PROT_HALF  = 2'h1;
    localparam logic [15:0] LIM_BOOT   = 16'h0200;
    localparam logic [15:0] LIM_HALF4K = 16'h0800;
    localparam logic [15:0] LIM_HALF8K = 16'h1000;
    localparam logic [15:0] LIM_ALL4K  = 16'h1000;
    localparam logic [15:0] LIM_ALL8K  = 16'h2000;

    // Erase time and its cycle count at the 25 ns clock
    localparam int ERASE_TIME_NS = 2000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int ERASE_CYCLES  = ERASE_TIME_NS / CLK_PERIOD_NS;

    // Register bus request
    typedef struct packed {
        logic                 we;
        logic                 re;
        logic [2:0]           addr;
        logic [DATA_W-1:0]    wdata;
    } fsrec_bus_req_s;

    // Control register contents
    typedef struct packed {
        logic config_space_select;
        logic free;
        logic err;
        logic write_enable_bit;
        logic wr;
        logic rd;
    } fsrec_ctrl_s;

    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_RD_ACC = 7'b0000010,
        ST_RD_END = 7'b0000100,
        ST_ER_SU1 = 7'b0001000,
        ST_ER_SU2 = 7'b0010000,
        ST_ER_CLR = 7'b0100000,
        ST_ER_WT  = 7'b1000000
    } fsrec_state_e;

endpackage

/* File: testbench.sv */
`timescale 1ns/1ps
// Self-checking bench for the flash sequencer
module testbench;
    import fsrec_pkg::*;
    localparam int EC = 64;
    typedef struct packed {
        logic [1:0]  prot;
        logic [15:0] addr;
        logic        ok;
        logic [1:0]  prot4;
        logic        ok4;
    } fsrec_row_s;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [1:0]     prot = 2'h3;
    logic [1:0]     prot4 = 2'h3;
    logic [7:0]     rdata_4k;
    logic           stall_4k;
    logic           squash_4k;
    int             n4k = 0;
    fsrec_bus_req_s bus_req;
    logic [7:0]     rdata;
    logic           stall;
    logic           squash;
    int             n_fail = 0;
    int             check_count = 0;
    fsrec_row_s     rows [9] = '{'{2'h3, 16'h0000, 1'b1, 2'h3, 1'b1},
        '{2'h2, 16'h01ff, 1'b0, 2'h2, 1'b0}, '{2'h2, 16'h0200, 1'b1, 2'h2, 1'b1},
        '{2'h1, 16'h0fff, 1'b0, 2'h1, 1'b1}, '{2'h1, 16'h1000, 1'b1, 2'h3, 1'b1},
        '{2'h0, 16'h1fe0, 1'b0, 2'h3, 1'b1}, '{2'h1, 16'h07ff, 1'b0, 2'h1, 1'b0},
        '{2'h1, 16'h0800, 1'b0, 2'h1, 1'b1}, '{2'h0, 16'h0fe0, 1'b0, 2'h0, 1'b0}};
    always #12.5 clk = ~clk;
    fsrec_ctrl #(.ERASE_CYCLES(EC)) dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata_q(rdata), .self_write_protect_field(prot), .cpu_stall(stall),
        .instr_squash(squash));
    fsrec_core #(.EC(EC)) core (.clk(clk), .cpu_stall(stall), .instr_squash(squash),
        .bus_rdata_q(rdata), .bus_req(bus_req));
    // Second sequencer with the 4 kW protect ranges, on the same bus
    fsrec_ctrl #(.ERASE_CYCLES(EC), .ARRAY_8KW(1'b0)) dut_4k (.clk(clk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_rdata_q(rdata_4k), .self_write_protect_field(prot4),
        .cpu_stall(stall_4k), .instr_squash(squash_4k));
    // Stall cycles of the 4 kW sequencer, sampled mid-cycle
    always @(negedge clk) begin
        if (stall_4k !== 1'b0) n4k++;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #500000;
        n_fail++;
        end_sim();
    end
    // Main sequence
    initial begin
        int         n;
        int         sq;
        logic [7:0] d;
        logic [15:0] w;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        core.rd(OFS_DATA_HIGH, d);
        chk("data_high_rst", 16'h0000, {8'h00, d});
        // Protection table
        for (int i = 0; i < 9; i++) begin
            core.idle();
            prot <= rows[i].prot;
            prot4 <= rows[i].prot4;
            n4k = 0;
            core.erase(rows[i].addr, UNLOCK_KEY2, 8'h16, n);
            chk("stall", rows[i].ok ? 16'(EC) : 16'h0000, 16'(n));
            chk("stall_4k", rows[i].ok4 ? 16'(EC) : 16'h0000, 16'(n4k));
            core.rd(OFS_CTRL, d);
            chk("ctrl", rows[i].ok ? 16'h0014 : 16'h001c, {8'h00, d});
            chk("ctrl_4k", rows[i].ok4 ? 16'h0014 : 16'h001c, {8'h00, rdata_4k});
            core.wr(OFS_CTRL, 8'h00);
            $display("row %0d done", i);
        end
        // Program read of an erased word, then software overwrite
        core.pread(16'h101f, sq, w);
        chk("squash_slot", 16'h0002, 16'(sq));
        chk("word", 16'h3fff, w);
        core.rd(OFS_CTRL, d);
        chk("ctrl_rd", 16'h0000, {8'h00, d & 8'h01});
        core.wr(OFS_DATA_LOW, 8'h5a);
        core.rd(OFS_DATA_LOW, d);
        chk("data_sw", 16'h005a, {8'h00, d});
        $display("read test done");
        // Broken unlock, write enable clear, then a good erase
        core.idle();
        prot <= 2'h3;
        prot4 <= 2'h3;
        core.erase(16'h1000, UNLOCK_KEY1, 8'h16, n);
        chk("bad_key", 16'h0000, 16'(n));
        core.wr(OFS_CTRL, 8'h00);
        core.erase(16'h1000, UNLOCK_KEY2, 8'h12, n);
        chk("no_write_enable_bit", 16'h0000, 16'(n));
        core.wr(OFS_CTRL, 8'h00);
        core.erase(16'h0000, UNLOCK_KEY2, 8'h16, n);
        chk("good", 16'(EC), 16'(n));
        core.rd(OFS_DATA_LOW, d);
        chk("data_held", 16'h005a, {8'h00, d});
        // Unmapped index and write-only port
        core.wr(3'h6, 8'hff);
        core.rd(3'h6, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        core.rd(OFS_UNLOCK, d);
        chk("unlock_rd", 16'h0000, {8'h00, d});
        $display("refusal test done");
        // Reset in mid-run brings the registers back to their reset values
        core.wr(OFS_ADDR_LOW, 8'hab);
        core.idle();
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        core.rd(OFS_ADDR_LOW, d);
        chk("addr_low_rst", 16'h0000, {8'h00, d});
        core.rd(OFS_DATA_LOW, d);
        chk("data_low_rst", 16'h0000, {8'h00, d});
        core.rd(OFS_CTRL, d);
        chk("ctrl_rst", 16'h0000, {8'h00, d});
        $display("reset test done");
        core.idle();
        end_sim();
    end
endmodule
bind fsrec_ctrl fsrec_ctrl_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk(clk),
    .rst_n(rst_n), .bus_req(bus_req), .bus_rdata_q(bus_rdata_q),
    .self_write_protect_field(self_write_protect_field), .cpu_stall(cpu_stall),
    .instr_squash(instr_squash));
